// File: sep_eeprom.sv
// Two-wire serial memory target: pin sampler, event crossing, protocol engine and array.
`timescale 1ns/1ns

// =========================================================================
// Overview of operation
// - Data bits are taken at the serial clock's rising edge and the outgoing bit changes only after its falling edge.
// - The data line is open drain, so the device only pulls it low or lets it go.
// - The device answers only when the select bits in the address byte equal its three strapped inputs.
// - Select and write-protect inputs read as low from reset until their samplers settle.
// - While write protect is high no byte reaches the array, and while it is low writes proceed.
// - Storage is 32,768 bytes, each picked by a byte address sent over the bus.
// - A page write takes up to 64 bytes inside one page, and shorter runs too.
// - An accepted write is followed by a self-timed programming cycle of at most 5 ms.
// - Random reads start at a given address and sequential reads walk on through following bytes.
// - The bus may run at 100 kHz, 400 kHz or 1 MHz.
module sep_eeprom #(
    parameter int WR_CYCLES = sep_pkg::WR_CYCLES,
    parameter logic [3:0] DEV_TYPE = sep_pkg::DEV_TYPE_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_level,
    output logic sda_value,
    output logic sda_oe,
    input wire logic addr_select_bit0,
    input wire logic addr_select_bit1,
    input wire logic addr_select_bit2,
    input wire logic write_protect,
    output logic wr_busy
);
    import sep_pkg::*;

    // Settled level of a three-stage synchroniser: a change counts once stages two and three agree.
    function automatic logic settle(input logic [SYNC_LEN-1:0] s, input logic st);
        settle = (s[1] == s[2]) ? s[2] : st;
    endfunction : settle

    sep_link_s lk_q, lk_d;
    sep_core_s cq, cd;
    logic lk_pend;
    logic scl_new;
    logic sda_new;
    logic [SEL_W-1:0] sel_pins;
    logic push, pop, buf_in_rdy, ev_new, match;
    sep_ev_s ev_out;
    logic mem_we;
    logic [DATA_W-1:0] mem_rdata;

    assign sel_pins = {addr_select_bit2, addr_select_bit1, addr_select_bit0};

    // =====================================================================
    // Link domain: samples the bus pins and hands each edge over as one word
    // Four-phase-free toggle handshake; the settled levels freeze while a word
    // is in flight, so an edge is delayed rather than lost.
    always_comb begin
        lk_d = lk_q;
        lk_pend = (lk_q.ack_s[1] != lk_q.req);
        scl_new = settle(lk_q.scl_s, lk_q.scl_st);
        sda_new = settle(lk_q.sda_s, lk_q.sda_st);
        lk_d.scl_s = {lk_q.scl_s[1:0], scl};
        lk_d.sda_s = {lk_q.sda_s[1:0], sda_level};
        lk_d.ack_s = {lk_q.ack_s[0], cq.ack};
        if (!lk_pend) begin
            lk_d.scl_st = scl_new;
            lk_d.sda_st = sda_new;
            if (scl_new != lk_q.scl_st) begin
                // The rising edge carries the data bit seen with it.
                lk_d.ev = '{kind: (scl_new ? EV_RISE : EV_FALL), bit_v: sda_new};
                lk_d.req = ~lk_q.req;
            end else if (lk_q.scl_st && (sda_new != lk_q.sda_st)) begin
                lk_d.ev = '{kind: (sda_new ? EV_STOP : EV_START), bit_v: 1'b0};
                lk_d.req = ~lk_q.req;
            end
        end
    end

    // Link domain register; the fast sampling clock keeps up with a 1 MHz bus.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lk_q <= LINK_RST;
        end else begin
            lk_q <= lk_d;
        end
    end

    // =====================================================================
    // Core domain: strap sampling, event buffer, protocol engine
    always_comb begin
        cd = cq;
        mem_we = 1'b0;
        cd.rd_ok = 1'b1;
        // Straps and write protect pass the three-stage sampler; reset leaves them low.
        cd.wp_s = {cq.wp_s[1:0], write_protect};
        cd.wp_st = settle(cq.wp_s, cq.wp_st);
        for (int i = 0; i < SEL_W; i++) begin
            cd.sel_s[i] = {cq.sel_s[i][1:0], sel_pins[i]};
            cd.sel_st[i] = settle(cq.sel_s[i], cq.sel_st[i]);
        end

        // Two-entry buffer; when full the handshake is not answered, which stalls the link side.
        cd.req_s = {cq.req_s[0], lk_q.req};
        ev_new = (cq.req_s[1] != cq.ack);
        buf_in_rdy = (cq.cnt != 2'h2);
        push = ev_new && buf_in_rdy;
        ev_out = cq.fifo[cq.rd_p];
        pop = (cq.cnt != 2'h0) && cq.rd_ok;
        if (push) begin
            cd.fifo[cq.wr_p] = lk_q.ev;
            cd.wr_p = ~cq.wr_p;
            cd.ack = cq.req_s[1];
        end
        if (pop) begin
            cd.rd_p = ~cq.rd_p;
        end
        cd.cnt = 2'(cq.cnt + {1'b0, push} - {1'b0, pop});

        // Type code and strapped select bits must both match, and the array must be idle.
        match = (cq.sh[7:4] == DEV_TYPE) && (cq.sh[3:1] == cq.sel_st) && !cq.busy;

        // Programming timer runs on its own once the frame has ended.
        if (cq.busy) begin
            cd.tmr = TMR_W'(cq.tmr - 1'b1);
            if (cq.tmr == '0) begin
                cd.busy = 1'b0;
            end
        end

        if (pop) begin
            case (ev_out.kind)
                EV_START: begin
                    cd.state = ST_RXBYTE;
                    cd.idx = IDX_DEV;
                    cd.bc = '0;
                    cd.oe = 1'b0;
                end
                EV_STOP: begin
                    cd.state = ST_IDLE;
                    cd.oe = 1'b0;
                    cd.wrote = 1'b0;
                    if (cq.wrote) begin
                        cd.busy = 1'b1;
                        cd.tmr = TMR_W'(WR_CYCLES - 1);
                    end
                end
                EV_RISE: begin
                    case (cq.state)
                        ST_RXBYTE: begin
                            if (cq.bc != BYTE_BITS) begin
                                cd.sh = {cq.sh[6:0], ev_out.bit_v};
                                cd.bc = 4'(cq.bc + 1'b1);
                            end
                        end
                        ST_TXBYTE: begin
                            cd.sh = {cq.sh[6:0], 1'b0};
                            cd.bc = 4'(cq.bc + 1'b1);
                        end
                        ST_ACKIN: cd.nack = ev_out.bit_v;
                        default: ;
                    endcase
                end
                EV_FALL: begin
                    case (cq.state)
                        ST_RXBYTE: begin
                            if (cq.bc == BYTE_BITS) begin
                                cd.state = ST_ACKOUT;
                                cd.oe = 1'b1;
                                cd.idx = (cq.idx == IDX_DATA) ? IDX_DATA : sep_idx_e'(cq.idx + 2'h1);
                                case (cq.idx)
                                    IDX_DEV: begin
                                        cd.rw = cq.sh[0];
                                        if (!match) begin
                                            cd.state = ST_IDLE;
                                            cd.oe = 1'b0;
                                        end
                                    end
                                    IDX_HI: cd.ptr[ADDR_W-1:8] = cq.sh[ADDR_W-9:0];
                                    IDX_LO: cd.ptr[7:0] = cq.sh;
                                    default: begin
                                        // Protected bytes are still acknowledged but never stored.
                                        mem_we = !cq.wp_st;
                                        cd.wrote = cq.wrote || !cq.wp_st;
                                        cd.ptr[PAGE_W-1:0] = PAGE_W'(cq.ptr[PAGE_W-1:0] + 1'b1);
                                    end
                                endcase
                            end
                        end
                        ST_ACKOUT: begin
                            cd.bc = '0;
                            if (cq.rw) begin
                                cd.state = ST_TXBYTE;
                                cd.sh = mem_rdata;
                                cd.oe = ~mem_rdata[7];
                            end else begin
                                cd.state = ST_RXBYTE;
                                cd.oe = 1'b0;
                            end
                        end
                        ST_TXBYTE: begin
                            if (cq.bc == BYTE_BITS) begin
                                cd.state = ST_ACKIN;
                                cd.oe = 1'b0;
                                cd.ptr = ADDR_W'(cq.ptr + 1'b1);
                                cd.rd_ok = 1'b0;
                            end else begin
                                cd.oe = ~cq.sh[7];
                            end
                        end
                        ST_ACKIN: begin
                            if (!cq.nack) begin
                                cd.state = ST_TXBYTE;
                                cd.bc = '0;
                                cd.sh = mem_rdata;
                                cd.oe = ~mem_rdata[7];
                            end else begin
                                cd.state = ST_IDLE;
                            end
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Core domain register; the clock enable freezes every field.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cq <= CORE_RST;
        end else if (ce) begin
            cq <= cd;
        end
    end

    // Writes go straight to the array; the address pointer also selects the read byte.
    sep_mem #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_mem (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .we(mem_we),
        .waddr(cq.ptr),
        .wdata(cq.sh),
        .raddr(cq.ptr),
        .rdata(mem_rdata)
    );

    // The data pin is only ever pulled low: its value flop never leaves zero.
    assign sda_value = cq.sda_o;
    assign sda_oe = cq.oe;
    assign wr_busy = cq.busy;

    // =====================================================================
    // Checks
    logic ast_drv_ev, ast_dev_ack, ast_tx_end;
    logic [ADDR_W-PAGE_W-1:0] ast_page;
    logic [PAGE_W-1:0] ast_low_next;
    logic [ADDR_W-1:0] ast_ptr_next;

    assign ast_drv_ev = pop && (ev_out.kind != EV_RISE);
    assign ast_dev_ack = pop && (ev_out.kind == EV_FALL) && (cq.state == ST_RXBYTE)
                         && (cq.bc == BYTE_BITS) && (cq.idx == IDX_DEV);
    assign ast_tx_end = pop && (ev_out.kind == EV_FALL) && (cq.state == ST_TXBYTE) && (cq.bc == BYTE_BITS);
    assign ast_page = cq.ptr[ADDR_W-1:PAGE_W];
    assign ast_low_next = PAGE_W'(cq.ptr[PAGE_W-1:0] + 1'b1);
    assign ast_ptr_next = ADDR_W'(cq.ptr + 1'b1);

    sequence s_stop_commit;
        ce && pop && (ev_out.kind == EV_STOP) && cq.wrote;
    endsequence

    sequence s_busy_load;
        cq.busy && (cq.tmr == TMR_W'(WR_CYCLES - 1));
    endsequence

    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst) sda_value == 1'b0)
        else $error("Data pin driven high.");
    AST_DRIVE_ON_FALL: assert property (@(posedge clk) disable iff (rst)
        $changed(sda_oe) |-> $past(ast_drv_ev))
        else $error("Data output changed without a falling clock or frame event.");
    AST_SELECT_MATCH: assert property (@(posedge clk) disable iff (rst)
        ast_dev_ack && ce && (cq.sh[3:1] != cq.sel_st) |=> !sda_oe)
        else $error("Acknowledged an address whose select bits differ from the straps.");
    AST_TYPE_MATCH: assert property (@(posedge clk) disable iff (rst)
        ast_dev_ack && ce && (cq.sh[7:4] != DEV_TYPE) |=> !sda_oe && (cq.state == ST_IDLE))
        else $error("Acknowledged an address with a foreign type code.");
    AST_WP_BLOCK: assert property (@(posedge clk) disable iff (rst) mem_we |-> !cq.wp_st)
        else $error("Array written while write protect is high.");
    AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (rst)
        mem_we && ce |=> (ast_page == $past(ast_page)) && (cq.ptr[PAGE_W-1:0] == $past(ast_low_next)))
        else $error("Page write pointer left its page.");
    AST_BUSY_START: assert property (@(posedge clk) disable iff (rst) s_stop_commit |=> s_busy_load)
        else $error("Programming cycle did not start at the end of a write frame.");
    AST_BUSY_BOUND: assert property (@(posedge clk) disable iff (rst)
        cq.busy && ce && (cq.tmr == '0) |=> !cq.busy ##1 !cq.busy || $past(pop))
        else $error("Programming cycle ran past its limit.");
    AST_SEQ_READ: assert property (@(posedge clk) disable iff (rst)
        ast_tx_end && ce |=> (cq.ptr == $past(ast_ptr_next)) && (cq.state == ST_ACKIN))
        else $error("Sequential read pointer did not advance by one.");
    AST_HOLD_WORD: assert property (@(posedge link_clk) disable iff (rst) lk_pend |=> $stable(lk_q.ev))
        else $error("Event word changed while in flight.");
    AST_BUF_LIMIT: assert property (@(posedge clk) disable iff (rst) cq.cnt <= 2'h2)
        else $error("Event buffer count beyond two.");

endmodule : sep_eeprom

// File: sep_pkg.sv
// Shared constants and types for the two-wire serial memory target.
package sep_pkg;

    // =====================================================================
    // Array geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam int SEL_W = 3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Device type code in the upper nibble of the address byte.
    localparam logic [3:0] DEV_TYPE_DEF = 4'hA;

    // =====================================================================
    // Timing
    localparam int T_WR_NS = 5000000;
    localparam int CLK_PERIOD_NS = 50;
    // A longest time rounds down to whole cycles.
    localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    localparam int SYNC_LEN = 3;

    // =====================================================================
    // Link events, engine states and byte positions
    typedef enum logic [1:0] {
        EV_START = 2'h0,
        EV_STOP = 2'h1,
        EV_RISE = 2'h2,
        EV_FALL = 2'h3
    } sep_ev_e;

    typedef struct packed {
        sep_ev_e kind;
        logic bit_v;
    } sep_ev_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RXBYTE = 3'h1,
        ST_ACKOUT = 3'h2,
        ST_TXBYTE = 3'h3,
        ST_ACKIN = 3'h4
    } sep_state_e;

    typedef enum logic [1:0] {
        IDX_DEV = 2'h0,
        IDX_HI = 2'h1,
        IDX_LO = 2'h2,
        IDX_DATA = 2'h3
    } sep_idx_e;

    // =====================================================================
    // State of each clock domain
    typedef struct packed {
        logic [SYNC_LEN-1:0] scl_s;
        logic [SYNC_LEN-1:0] sda_s;
        logic scl_st;
        logic sda_st;
        logic req;
        logic [1:0] ack_s;
        sep_ev_s ev;
    } sep_link_s;

    typedef struct packed {
        logic [1:0] req_s;
        logic ack;
        logic [SYNC_LEN-1:0] wp_s;
        logic wp_st;
        logic [SEL_W-1:0][SYNC_LEN-1:0] sel_s;
        logic [SEL_W-1:0] sel_st;
        sep_ev_s [1:0] fifo;
        logic wr_p;
        logic rd_p;
        logic [1:0] cnt;
        logic rd_ok;
        sep_state_e state;
        sep_idx_e idx;
        logic [3:0] bc;
        logic [DATA_W-1:0] sh;
        logic rw;
        logic nack;
        logic [ADDR_W-1:0] ptr;
        logic oe;
        logic sda_o;
        logic wrote;
        logic busy;
        logic [TMR_W-1:0] tmr;
    } sep_core_s;

    // The bus idles high, so the link samplers start high to avoid a false edge.
    localparam sep_link_s LINK_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_st: 1'b1, sda_st: 1'b1,
                                      req: 1'b0, ack_s: 2'h0, ev: 3'h0};
    localparam sep_core_s CORE_RST = '0;

endpackage : sep_pkg

// File: sep_mem.sv
// Byte-wide storage array with registered read data.
`timescale 1ns/1ns

module sep_mem #(
    parameter int DATA_W = sep_pkg::DATA_W,
    parameter int ADDR_W = sep_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    import sep_pkg::*;

    // =====================================================================
    // Storage
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];

    // One byte per address; the array itself has no reset.
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data leaves through a register, one cycle after the address.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= mem[raddr];
        end
    end

endmodule : sep_mem

// File: sep_ctl_model.sv
// Behavioural two-wire bus controller that drives the serial clock and pulls the data wire low.
`timescale 1ns/1ns

module sep_ctl_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    // =====================================================================
    // Bus timing
    // Quarter bit time in core clock cycles; the bench sets it to pick the bus rate.
    int q = 5;

    // The clock idles high so the target sees no edge between frames.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // =====================================================================
    // Bit-level tasks
    // Every change lands a fixed small delay after a core clock edge.
    task automatic wq();
        repeat (q) @(posedge clk);
        #2;
    endtask : wq

    // Start from idle or repeated start; data is released first so a start is always a fall.
    task automatic bus_start();
        sda_pull = 1'b0;
        wq();
        scl = 1'b1;
        wq();
        wq();
        sda_pull = 1'b1;
        wq();
        wq();
        scl = 1'b0;
        wq();
    endtask : bus_start

    // Stop leaves the clock high and the data line released, as the idle bus needs.
    task automatic bus_stop();
        sda_pull = 1'b1;
        wq();
        scl = 1'b1;
        wq();
        wq();
        sda_pull = 1'b0;
        wq();
        wq();
    endtask : bus_stop

    // Data changes only while the clock is low and is read in the middle of the high phase.
    task automatic xfer_bit(input logic b, output logic r);
        sda_pull = ~b;
        wq();
        scl = 1'b1;
        wq();
        r = sda_wire;
        wq();
        scl = 1'b0;
        wq();
    endtask : xfer_bit

    // Eight bits most significant first, then the acknowledge slot.
    task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] r, output logic a_out);
        int i;
        for (i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r[i]);
        end
        xfer_bit(a_in, a_out);
        sda_pull = 1'b0;
    endtask : byte_io
endmodule : sep_ctl_model

// File: sep_eeprom_tb_top.sv
// Self-checking bench for the two-wire serial memory target.
`timescale 1ns/1ns

module sep_eeprom_tb_top;
    import sep_pkg::*;

    // =====================================================================
    // Signals and bookkeeping
    localparam int WR_N = 400;
    localparam int LIMIT = 80000;
    logic clk, rst, ce, link_clk, scl, sda_pull, sda_wire, sda_value, sda_oe, wr_busy, write_protect, oe_prev;
    logic [2:0] sel;
    logic [14:0] base;
    int failures, num_checks, cyc, n, k, busy_cyc;
    logic [7:0] ref_mem [int];

    // Open-drain wire: anyone pulling wins, otherwise the pull-up.
    assign sda_wire = (sda_pull | sda_oe) ? 1'b0 : 1'b1;

    // Clocks are unrelated in phase.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #6 link_clk = ~link_clk;
    end

    sep_eeprom #(.WR_CYCLES(WR_N)) u_sep_eeprom (
        .clk(clk), .rst(rst), .ce(ce), .link_clk(link_clk), .scl(scl), .sda_level(sda_wire),
        .sda_value(sda_value), .sda_oe(sda_oe), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
        .addr_select_bit2(sel[2]), .write_protect(write_protect), .wr_busy(wr_busy)
    );

    sep_ctl_model u_sep_ctl_model (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

    // =====================================================================
    // Compare and closing tasks
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic complete_run();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // A hang costs a mismatch and ends the run through the same report.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            failures++;
            complete_run();
        end
    end

    // The device may only start or stop pulling while the clock is low, and never drives high.
    always @(negedge clk) begin
        if (!rst && sda_oe !== oe_prev) begin
            chk_bit(scl, 1'b0);
            chk_bit(sda_value, 1'b0);
        end
        oe_prev <= sda_oe;
        // Counts the coming rising edges that both run the core and see it busy.
        // The count runs on its own, so a programming cycle that starts before anyone waits is still counted in full.
        if (ce === 1'b1 && wr_busy === 1'b1) begin
            busy_cyc <= busy_cyc + 1;
        end
    end

    // =====================================================================
    // Frame tasks
    task automatic probe(input logic [7:0] dev, input logic exp_nak);
        logic ak;
        logic [7:0] r;
        u_sep_ctl_model.bus_start();
        u_sep_ctl_model.byte_io(dev, 1'b1, r, ak);
        chk_bit(ak, exp_nak);
        if (ak === 1'b0) begin
            u_sep_ctl_model.byte_io(8'hFF, 1'b1, r, ak);
        end
        u_sep_ctl_model.bus_stop();
    endtask : probe

    // Page write; the reference pointer wraps inside the 64-byte page.
    task automatic wr_frame(input logic [14:0] a, input int cnt, input logic prot);
        logic ak;
        logic [7:0] r, d;
        int i;
        u_sep_ctl_model.bus_start();
        u_sep_ctl_model.byte_io({DEV_TYPE_DEF, sel, 1'b0}, 1'b1, r, ak);
        chk_bit(ak, 1'b0);
        u_sep_ctl_model.byte_io({1'b0, a[14:8]}, 1'b1, r, ak);
        u_sep_ctl_model.byte_io(a[7:0], 1'b1, r, ak);
        chk_bit(ak, 1'b0);
        for (i = 0; i < cnt; i++) begin
            d = 8'($urandom);
            u_sep_ctl_model.byte_io(d, 1'b1, r, ak);
            chk_bit(ak, 1'b0);
            if (!prot) begin
                ref_mem[int'({a[14:6], 6'(a[5:0] + i)})] = d;
            end
        end
        u_sep_ctl_model.bus_stop();
    endtask : wr_frame

    // Random read followed by a sequential run; the pointer walks the whole array.
    task automatic rd_frame(input logic [14:0] a, input int cnt);
        logic ak;
        logic [7:0] r;
        int i;
        u_sep_ctl_model.bus_start();
        u_sep_ctl_model.byte_io({DEV_TYPE_DEF, sel, 1'b0}, 1'b1, r, ak);
        u_sep_ctl_model.byte_io({1'b0, a[14:8]}, 1'b1, r, ak);
        u_sep_ctl_model.byte_io(a[7:0], 1'b1, r, ak);
        u_sep_ctl_model.bus_start();
        u_sep_ctl_model.byte_io({DEV_TYPE_DEF, sel, 1'b1}, 1'b1, r, ak);
        chk_bit(ak, 1'b0);
        for (i = 0; i < cnt; i++) begin
            u_sep_ctl_model.byte_io(8'hFF, (i == cnt - 1), r, ak);
            chk_word(32'(r), 32'(ref_mem[int'(15'(a + i))]));
        end
        u_sep_ctl_model.bus_stop();
    endtask : rd_frame

    // Waits out the busy time while dropping the enable at random; the length is the enabled busy edges since s.
    task automatic busy_len(input int s, output int len);
        int w;
        w = 0;
        while (wr_busy !== 1'b1 && w < 40) begin
            @(posedge clk);
            #2;
            w++;
        end
        while (wr_busy === 1'b1 && w < 4000) begin
            @(posedge clk);
            #2;
            w++;
            ce = ($urandom % 4) != 0;
        end
        ce = 1'b1;
        len = busy_cyc - s;
    endtask : busy_len

    // =====================================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        write_protect = 1'b0;
        failures = 0;
        num_checks = 0;
        void'($urandom(62002));
        sel = 3'($urandom);
        base = {9'($urandom), 6'h00};
        repeat (16) @(posedge clk);
        #2;
        rst = 1'b0;
        repeat (10) @(posedge clk);
        #2;
        // Only the strapped select value is answered; a wrong type code never is.
        for (k = 0; k < 8; k++) begin
            probe({DEV_TYPE_DEF, 3'(k), 1'b1}, 3'(k) != sel);
        end
        probe({4'h5, sel, 1'b1}, 1'b1);
        $display("select test done");
        // A page write that wraps, its programming time, and refusal while busy.
        k = busy_cyc;
        wr_frame(base + 15'd60, 8, 1'b0);
        fork
            busy_len(k, n);
            probe({DEV_TYPE_DEF, sel, 1'b1}, 1'b1);
        join
        chk_word(32'(n), 32'(WR_N));
        $display("page write test done");
        wr_frame(base + 15'd64, 4, 1'b0);
        repeat (WR_N + 60) @(posedge clk);
        #2;
        chk_bit(wr_busy, 1'b0);
        rd_frame(base + 15'd60, 8);
        rd_frame(base, 4);
        $display("read test done");
        // Protected writes are acked but neither stored nor programmed.
        write_protect = 1'b1;
        repeat (5) @(posedge clk);
        #2;
        wr_frame(base, 4, 1'b1);
        n = 0;
        repeat (WR_N + 60) begin
            @(posedge clk);
            #2;
            n += (wr_busy === 1'b1) ? 1 : 0;
        end
        chk_word(32'(n), 32'h0);
        write_protect = 1'b0;
        rd_frame(base, 4);
        $display("protect test done");
        // Standard, fast and fast-plus bus rates.
        for (k = 0; k < 3; k++) begin
            u_sep_ctl_model.q = (k == 0) ? 50 : (k == 1) ? 13 : 5;
            rd_frame(base + 15'd62, 3);
        end
        $display("rate test done");
        complete_run();
    end
endmodule : sep_eeprom_tb_top
